/* File: atm_cell_header_screen_ctrl.sv */
// Idle header registers and receive cell validation for the cell layer
// Function
// - idle octet 3 is VCI, resets zero
// - idle octet 4 high nibble is VCI low
// - octet 4 payload type, CLP resets one
// - header reject inverts the match acceptance
// - idle delete drops idle-matching cells
// - descrambler x^43+1 on payload when enabled
// - coset applied before HEC compare when enabled
// - correction state machine or detect only
// - check disable ignores HEC result
// - receiver disable acts at cell boundary
// - bypass forwards cells without delineation
// - 32-bit masked match selects forwarded cells
// - match octets 1 and 2 reset zero
// - set mask bit ignores header bit
// - idle header goes into generated idle cells
module atm_cell_header_screen_ctrl (
	input  wire logic        CLK_I,
	input  wire logic        RESET_N_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [7:0]  WR_DATA_I,
	input  wire logic        WR_STROBE_I,
	input  wire logic        RD_STROBE_I,
	output logic [7:0]       RD_DATA_O,
	input  wire logic [7:0]  TX_IDLE_OCTET1_I,
	output logic [31:0]      TX_IDLE_HEADER_O,
	input  wire logic [15:0] RX_MATCH_OCTET34_I,
	input  wire logic [31:0] RX_HEADER_MASK_I,
	input  wire logic [31:0] RX_IDLE_HEADER_VALUE_I,
	input  wire logic [31:0] RX_IDLE_HEADER_MASK_I,
	input  wire logic        CELL_ALIGNED_I,
	input  wire logic [7:0]  RX_DATA_I,
	input  wire logic        RX_VALID_I,
	input  wire logic        RX_SOC_I,
	output logic [7:0]       CELL_DATA_O,
	output logic             CELL_VALID_O,
	output logic             CELL_SOC_O,
	output logic             HEC_DETECT_MODE_O
);

	localparam int DEPTH = cell_screen_pkg::PIPE_DEPTH;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0]  cell_validation_control_r, cell_validation_control_nxt;
	logic [7:0]  idle2_r, idle2_nxt;
	logic [7:0]  idle3_r, idle3_nxt;
	logic [7:0]  idle4_r, idle4_nxt;
	logic [7:0]  match1_r, match1_nxt;
	logic [7:0]  match2_r, match2_nxt;
	logic [7:0]  rd_data_r, rd_data_nxt;
	logic [31:0] idle_hdr_r, idle_hdr_nxt;

	always_comb
	begin
		cell_validation_control_nxt    = cell_validation_control_r;
		idle2_nxt   = idle2_r;
		idle3_nxt   = idle3_r;
		idle4_nxt   = idle4_r;
		match1_nxt  = match1_r;
		match2_nxt  = match2_r;
		rd_data_nxt = rd_data_r;
		if (WR_STROBE_I)
		begin
			unique case (ADDR_I)
				cell_screen_pkg::OFF_CELL_VALIDATION: cell_validation_control_nxt = WR_DATA_I;
				cell_screen_pkg::OFF_TX_IDLE_OCTET2: idle2_nxt = WR_DATA_I;
				cell_screen_pkg::OFF_TX_IDLE_OCTET3: idle3_nxt = WR_DATA_I;
				cell_screen_pkg::OFF_TX_IDLE_OCTET4: idle4_nxt = WR_DATA_I;
				cell_screen_pkg::OFF_RX_MATCH_OCTET1: match1_nxt = WR_DATA_I;
				cell_screen_pkg::OFF_RX_MATCH_OCTET2: match2_nxt = WR_DATA_I;
				default: ;
			endcase
		end
		if (RD_STROBE_I)
		begin
			unique case (ADDR_I)
				cell_screen_pkg::OFF_CELL_VALIDATION: rd_data_nxt = cell_validation_control_r;
				cell_screen_pkg::OFF_TX_IDLE_OCTET2: rd_data_nxt = idle2_r;
				cell_screen_pkg::OFF_TX_IDLE_OCTET3: rd_data_nxt = idle3_r;
				cell_screen_pkg::OFF_TX_IDLE_OCTET4: rd_data_nxt = idle4_r;
				cell_screen_pkg::OFF_RX_MATCH_OCTET1: rd_data_nxt = match1_r;
				cell_screen_pkg::OFF_RX_MATCH_OCTET2: rd_data_nxt = match2_r;
				default: rd_data_nxt = 8'h00;
			endcase
		end
		// Octet 1 comes from its neighbour; the rest is held here
		idle_hdr_nxt = {TX_IDLE_OCTET1_I, idle2_r, idle3_r, idle4_r};
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			cell_validation_control_r     <= cell_screen_pkg::RST_CELL_VALIDATION;
			idle2_r    <= cell_screen_pkg::RST_TX_IDLE_OCTET2;
			idle3_r    <= cell_screen_pkg::RST_TX_IDLE_OCTET3;
			idle4_r    <= cell_screen_pkg::RST_TX_IDLE_OCTET4;
			match1_r   <= cell_screen_pkg::RST_RX_MATCH;
			match2_r   <= cell_screen_pkg::RST_RX_MATCH;
			rd_data_r  <= 8'h00;
			idle_hdr_r <= 32'h00000000;
		end
		else
		begin
			cell_validation_control_r     <= cell_validation_control_nxt;
			idle2_r    <= idle2_nxt;
			idle3_r    <= idle3_nxt;
			idle4_r    <= idle4_nxt;
			match1_r   <= match1_nxt;
			match2_r   <= match2_nxt;
			rd_data_r  <= rd_data_nxt;
			idle_hdr_r <= idle_hdr_nxt;
		end
	end

	assign RD_DATA_O        = rd_data_r;
	assign TX_IDLE_HEADER_O = idle_hdr_r;

	// ----------------------------------------------------------------
	// Header check helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 31; i >= 0; i--)
		begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? cell_screen_pkg::HEC_POLY : 8'h00);
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// Receive cell path
	// ----------------------------------------------------------------
	logic [5:0]                  cnt_r, cnt_nxt, idx;
	logic [31:0]                 hdr_r, hdr_nxt, hdr_fixed, fix_vec;
	logic                        gate_r, gate_nxt;
	logic                        keep_r, keep_nxt;
	cell_screen_pkg::hec_state_t hec_r, hec_nxt;
	cell_screen_pkg::cell_octet_t pipe_r [DEPTH];
	cell_screen_pkg::cell_octet_t pipe_nxt [DEPTH];
	logic [7:0]                  out_data_r, out_data_nxt;
	logic                        out_valid_r, out_valid_nxt;
	logic                        out_soc_r, out_soc_nxt;
	logic [31:0]                 full_hdr;
	logic [7:0]                  expect_hec, syndrome, descr_data;
	logic                        hec_ok, cell_keep, fire5, match_hit, idle_hit;
	logic                        single_hec_bit;

	assign idx      = RX_SOC_I ? 6'h01 : cnt_r + 6'h01;
	assign fire5    = RX_VALID_I && (idx == cell_screen_pkg::HEC_OCTET);
	assign full_hdr = hdr_r;
	assign expect_hec = crc8(full_hdr)
		^ (cell_validation_control_r[cell_screen_pkg::BIT_COSET_EN] ? cell_screen_pkg::HEC_COSET : 8'h00);
	assign syndrome = RX_DATA_I ^ expect_hec;
	assign single_hec_bit = (syndrome != 8'h00) && ((syndrome & (syndrome - 8'h01)) == 8'h00);

	// HEC is linear, so a lone header bit error leaves that bit's own CRC
	always_comb
	begin
		fix_vec = 32'h00000000;
		for (int i = 0; i < 32; i++)
		begin
			if (crc8(32'h00000001 << i) == syndrome)
				fix_vec = 32'h00000001 << i;
		end
	end

	header_matcher #(
		.WIDTH(32)
	) u_match (
		.hdr_i   (hdr_fixed),
		.value_i ({match1_r, match2_r, RX_MATCH_OCTET34_I}),
		.mask_i  (RX_HEADER_MASK_I),
		.match_o (match_hit)
	);

	header_matcher #(
		.WIDTH(32)
	) u_idle (
		.hdr_i   (hdr_fixed),
		.value_i (RX_IDLE_HEADER_VALUE_I),
		.mask_i  (RX_IDLE_HEADER_MASK_I),
		.match_o (idle_hit)
	);

	payload_descrambler u_descr (
		.clk_i     (CLK_I),
		.reset_n_i (RESET_N_I),
		.step_i    (RX_VALID_I && idx > cell_screen_pkg::HEC_OCTET
			&& idx <= cell_screen_pkg::CELL_OCTETS),
		.data_i    (RX_DATA_I),
		.data_o    (descr_data)
	);

	always_comb
	begin
		hdr_fixed = full_hdr;
		hec_ok    = 1'b1;
		hec_nxt   = hec_r;
		if (!cell_validation_control_r[cell_screen_pkg::BIT_CHECK_DISABLE] && fire5)
		begin
			if (syndrome == 8'h00)
				hec_nxt = cell_screen_pkg::HEC_CORRECT;
			else
			begin
				hec_nxt = cell_screen_pkg::HEC_DETECT;
				hec_ok  = 1'b0;
				// One error is repaired only in the correcting state
				if (cell_validation_control_r[cell_screen_pkg::BIT_CORRECTION_EN]
					&& hec_r == cell_screen_pkg::HEC_CORRECT
					&& (single_hec_bit || fix_vec != 32'h00000000))
				begin
					hec_ok    = 1'b1;
					hdr_fixed = full_hdr ^ fix_vec;
				end
			end
		end
		cell_keep = gate_r && hec_ok
			&& (match_hit ^ cell_validation_control_r[cell_screen_pkg::BIT_HEADER_REJECT])
			&& !(idle_hit && cell_validation_control_r[cell_screen_pkg::BIT_IDLE_DELETE]);
	end

	always_comb
	begin
		cnt_nxt       = cnt_r;
		hdr_nxt       = hdr_r;
		gate_nxt      = gate_r;
		keep_nxt      = keep_r;
		pipe_nxt      = pipe_r;
		out_data_nxt  = out_data_r;
		out_soc_nxt   = out_soc_r;
		out_valid_nxt = 1'b0;
		if (RX_VALID_I)
		begin
			cnt_nxt = (idx > cell_screen_pkg::CELL_OCTETS) ? cnt_r : idx;
			if (idx == 6'h01)
			begin
				// Disable and delineation are sampled only at a cell start
				gate_nxt = !cell_validation_control_r[cell_screen_pkg::BIT_RECEIVER_DIS]
					&& (CELL_ALIGNED_I || cell_validation_control_r[cell_screen_pkg::BIT_DELIN_BYPASS]);
				keep_nxt = 1'b0;
			end
			if (idx < cell_screen_pkg::HEC_OCTET)
				hdr_nxt = {hdr_r[23:0], RX_DATA_I};
			// Oldest octet leaves as the new one enters
			out_valid_nxt = pipe_r[DEPTH-1].keep;
			out_data_nxt  = pipe_r[DEPTH-1].data;
			out_soc_nxt   = pipe_r[DEPTH-1].soc;
			for (int i = DEPTH-1; i > 0; i--)
				pipe_nxt[i] = pipe_r[i-1];
			pipe_nxt[0].soc  = (idx == 6'h01);
			pipe_nxt[0].keep = keep_r && idx > cell_screen_pkg::HEC_OCTET
				&& idx <= cell_screen_pkg::CELL_OCTETS;
			pipe_nxt[0].data = (cell_validation_control_r[cell_screen_pkg::BIT_DESCRAMBLER_EN]
				&& idx > cell_screen_pkg::HEC_OCTET) ? descr_data : RX_DATA_I;
			if (fire5)
			begin
				keep_nxt = cell_keep;
				for (int i = 0; i < DEPTH; i++)
					pipe_nxt[i].keep = cell_keep;
				for (int i = 1; i < DEPTH; i++)
					pipe_nxt[i].data = hdr_fixed[8*(i-1) +: 8];
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			cnt_r       <= cell_screen_pkg::CELL_OCTETS;
			hdr_r       <= 32'h00000000;
			gate_r      <= 1'b0;
			keep_r      <= 1'b0;
			hec_r       <= cell_screen_pkg::HEC_CORRECT;
			out_data_r  <= 8'h00;
			out_valid_r <= 1'b0;
			out_soc_r   <= 1'b0;
			for (int i = 0; i < DEPTH; i++)
				pipe_r[i] <= '0;
		end
		else
		begin
			cnt_r       <= cnt_nxt;
			hdr_r       <= hdr_nxt;
			gate_r      <= gate_nxt;
			keep_r      <= keep_nxt;
			hec_r       <= hec_nxt;
			out_data_r  <= out_data_nxt;
			out_valid_r <= out_valid_nxt;
			out_soc_r   <= out_soc_nxt;
			pipe_r      <= pipe_nxt;
		end
	end

	assign CELL_DATA_O       = out_data_r;
	assign CELL_VALID_O      = out_valid_r;
	assign CELL_SOC_O        = out_soc_r;
	assign HEC_DETECT_MODE_O = hec_r[1];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_idle_octet2;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(WR_STROBE_I && ADDR_I == cell_screen_pkg::OFF_TX_IDLE_OCTET2)
			|-> ##2 TX_IDLE_HEADER_O[23:16] == $past(WR_DATA_I, 2);
	endproperty
	a_idle_octet2: assert property (p_idle_octet2) else $error("idle octet 2 not applied");

	property p_idle_octet3;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(WR_STROBE_I && ADDR_I == cell_screen_pkg::OFF_TX_IDLE_OCTET3)
			|-> ##2 TX_IDLE_HEADER_O[15:8] == $past(WR_DATA_I, 2);
	endproperty
	a_idle_octet3: assert property (p_idle_octet3) else $error("idle octet 3 not applied");

	property p_idle_octet4;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(WR_STROBE_I && ADDR_I == cell_screen_pkg::OFF_TX_IDLE_OCTET4)
			|-> ##2 TX_IDLE_HEADER_O[7:0] == $past(WR_DATA_I, 2);
	endproperty
	a_idle_octet4: assert property (p_idle_octet4) else $error("idle octet 4 not applied");

	property p_reject;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(fire5 && gate_r && hec_ok && !idle_hit)
			|-> cell_keep == (match_hit ^ cell_validation_control_r[cell_screen_pkg::BIT_HEADER_REJECT]);
	endproperty
	a_reject: assert property (p_reject) else $error("header screen decision wrong");

	property p_idle_drop;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(fire5 && idle_hit && cell_validation_control_r[cell_screen_pkg::BIT_IDLE_DELETE])
			|=> !keep_r ##1 !CELL_VALID_O;
	endproperty
	a_idle_drop: assert property (p_idle_drop) else $error("idle cell not deleted");

	property p_coset;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(fire5 && cell_validation_control_r[cell_screen_pkg::BIT_COSET_EN]
			&& RX_DATA_I == (crc8(hdr_r) ^ cell_screen_pkg::HEC_COSET)) |-> hec_ok;
	endproperty
	a_coset: assert property (p_coset) else $error("good cosetted header rejected");

	property p_detect_only;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(fire5 && syndrome != 8'h00 && !cell_validation_control_r[cell_screen_pkg::BIT_CORRECTION_EN]
			&& !cell_validation_control_r[cell_screen_pkg::BIT_CHECK_DISABLE]) |-> !hec_ok ##1 HEC_DETECT_MODE_O;
	endproperty
	a_detect_only: assert property (p_detect_only) else $error("errored header passed");

	property p_check_off;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(fire5 && cell_validation_control_r[cell_screen_pkg::BIT_CHECK_DISABLE]) |-> hec_ok;
	endproperty
	a_check_off: assert property (p_check_off) else $error("HEC used while disabled");

	property p_rx_disable;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(RX_VALID_I && idx == 6'h01 && cell_validation_control_r[cell_screen_pkg::BIT_RECEIVER_DIS])
			|=> !gate_r;
	endproperty
	a_rx_disable: assert property (p_rx_disable) else $error("disabled receiver took cell");

	property p_delin;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(RX_VALID_I && idx == 6'h01 && !cell_validation_control_r[cell_screen_pkg::BIT_RECEIVER_DIS]
			&& (CELL_ALIGNED_I || cell_validation_control_r[cell_screen_pkg::BIT_DELIN_BYPASS])) |=> gate_r;
	endproperty
	a_delin: assert property (p_delin) else $error("aligned or bypassed cell gated");

	c_kept: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) fire5 && cell_keep);
	c_fixed: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
		fire5 && syndrome != 8'h00 && hec_ok);
	c_out_soc: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CELL_VALID_O && CELL_SOC_O);

endmodule

/* File: cell_screen_pkg.sv */
// Constants, types and the register map shared by the cell screening block
package cell_screen_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CELL_VALIDATION = 8'h08;
	localparam logic [7:0] OFF_TX_IDLE_OCTET2  = 8'h21;
	localparam logic [7:0] OFF_TX_IDLE_OCTET3  = 8'h22;
	localparam logic [7:0] OFF_TX_IDLE_OCTET4  = 8'h23;
	localparam logic [7:0] OFF_RX_MATCH_OCTET1 = 8'h24;
	localparam logic [7:0] OFF_RX_MATCH_OCTET2 = 8'h25;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CELL_VALIDATION = 8'h70;
	localparam logic [7:0] RST_TX_IDLE_OCTET2  = 8'h00;
	localparam logic [7:0] RST_TX_IDLE_OCTET3  = 8'h00;
	localparam logic [7:0] RST_TX_IDLE_OCTET4  = 8'h01;
	localparam logic [7:0] RST_RX_MATCH        = 8'h00;

	// ----------------------------------------------------------------
	// Cell validation control bit positions
	// ----------------------------------------------------------------
	localparam int BIT_HEADER_REJECT   = 7;
	localparam int BIT_IDLE_DELETE     = 6;
	localparam int BIT_DESCRAMBLER_EN  = 5;
	localparam int BIT_COSET_EN        = 4;
	localparam int BIT_CORRECTION_EN   = 3;
	localparam int BIT_CHECK_DISABLE   = 2;
	localparam int BIT_RECEIVER_DIS    = 1;
	localparam int BIT_DELIN_BYPASS    = 0;

	// ----------------------------------------------------------------
	// Cell geometry and header check constants
	// ----------------------------------------------------------------
	localparam logic [5:0] CELL_OCTETS   = 6'h35;
	localparam logic [5:0] HEC_OCTET     = 6'h05;
	localparam int         PIPE_DEPTH    = 5;
	localparam int         SCRAMBLE_LAG  = 43;
	localparam logic [7:0] HEC_COSET     = 8'h55;
	localparam logic [7:0] HEC_POLY      = 8'h07;

	typedef enum logic [1:0]
	{
		HEC_CORRECT = 2'b01,
		HEC_DETECT  = 2'b10
	} hec_state_t;

	typedef struct packed
	{
		logic       soc;
		logic       keep;
		logic [7:0] data;
	} cell_octet_t;

endpackage

/* File: header_matcher.sv */
// Masked compare of a received header against a programmed value
module header_matcher #(
	parameter int WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] hdr_i,
	input  wire logic [WIDTH-1:0] value_i,
	input  wire logic [WIDTH-1:0] mask_i,
	output logic                  match_o
);

	logic [WIDTH-1:0] bit_ok;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			// A set mask bit takes that header bit out of the compare
			assign bit_ok[g] = mask_i[g] | (hdr_i[g] == value_i[g]);
		end
	endgenerate

	assign match_o = &bit_ok;

endmodule

/* File: payload_descrambler.sv */
// Self-synchronising x^43+1 descrambler, one octet per step, first bit in msb
module payload_descrambler (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       step_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      data_o
);

	localparam int LAG = cell_screen_pkg::SCRAMBLE_LAG;

	logic [LAG-1:0]   hist_r;
	logic [LAG-1:0]   hist_nxt;
	logic [LAG+7:0]   seq;

	// Newest line bit sits at index 0
	assign seq = {hist_r, data_i};

	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_bit
			assign data_o[g] = seq[g] ^ seq[g+LAG];
		end
	endgenerate

	always_comb
	begin
		hist_nxt = hist_r;
		if (step_i)
			hist_nxt = seq[LAG-1:0];
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hist_r <= '0;
		else
			hist_r <= hist_nxt;
	end

endmodule

/* File: cell_source.sv */
// Far-side cell source that feeds received octets to the screen block
module cell_source (
	input  wire logic clk_i,
	output logic [7:0] data_o,
	output logic       valid_o,
	output logic       soc_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		data_o  = 8'h00;
		valid_o = 1'b0;
		soc_o   = 1'b0;
	end

	// ----------------------------------------------------------------
	// Header check octet, CRC-8 over 32 bits msb first
	// ----------------------------------------------------------------
	function automatic logic [7:0] hec_of(input logic [31:0] hdr, input logic coset);
		logic [7:0] crc;
		crc = 8'h00;
		for (int i = 31; i >= 0; i--)
			crc = {crc[6:0], 1'b0} ^ (((crc[7] ^ hdr[i]) == 1'b1) ? 8'h07 : 8'h00);
		return (coset == 1'b1) ? (crc ^ 8'h55) : crc;
	endfunction

	// ----------------------------------------------------------------
	// One whole cell, flip corrupts header and check octet on purpose
	// ----------------------------------------------------------------
	task automatic send(input logic [31:0] hdr, input logic [39:0] flip, input logic coset);
		logic [39:0] head;
		head = {hdr, hec_of(hdr, coset)} ^ flip;
		for (int n = 0; n < 53; n++)
		begin
			@(posedge clk_i);
			#1;
			valid_o = 1'b1;
			soc_o   = (n == 0);
			data_o  = (n < 5) ? head[39-8*n -: 8] : n[7:0];
		end
		@(posedge clk_i);
		#1;
		valid_o = 1'b0;
		soc_o   = 1'b0;
		// Released line must not keep showing the last octet
		data_o  = ~data_o;
	endtask
endmodule

/* File: tb_atm_cell_header_screen_ctrl.sv */
// Self-checking bench for the cell header screen and idle header registers
module tb_atm_cell_header_screen_ctrl;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed
	{
		logic [7:0]  ctrl;
		logic        aligned;
		logic [31:0] hdr;
		logic [39:0] flip;
		logic        coset;
		logic        keep;
	} cell_row_t;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rd_data;
	logic [31:0] idle_hdr;
	logic        aligned = 1'b1;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        rx_soc;
	logic [7:0]  cell_data;
	logic        cell_valid;
	logic        cell_soc;
	logic [7:0]  first_data;
	logic        first_soc;
	logic [7:0]  last_data;
	logic [7:0]  got;
	int          n_out = 0;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	cell_row_t   rows [14] = '{
		'{8'h70, 1'b1, 32'h12340010, 40'h0, 1'b1, 1'b1},
		'{8'h70, 1'b1, 32'h12350010, 40'h0, 1'b1, 1'b0},
		'{8'hf0, 1'b1, 32'h12350010, 40'h0, 1'b1, 1'b1},
		'{8'hf0, 1'b1, 32'h12340010, 40'h0, 1'b1, 1'b0},
		'{8'h70, 1'b0, 32'h12340010, 40'h0, 1'b1, 1'b0},
		'{8'h71, 1'b0, 32'h12340010, 40'h0, 1'b1, 1'b1},
		'{8'h72, 1'b1, 32'h12340010, 40'h0, 1'b1, 1'b0},
		'{8'h70, 1'b1, 32'h12340010, 40'h8000000000, 1'b1, 1'b0},
		'{8'h74, 1'b1, 32'h12340010, 40'h0000000080, 1'b1, 1'b1},
		'{8'h60, 1'b1, 32'h12340010, 40'h0, 1'b0, 1'b1},
		'{8'h60, 1'b1, 32'h12340010, 40'h0, 1'b1, 1'b0},
		'{8'h78, 1'b1, 32'h12340010, 40'h8000000000, 1'b1, 1'b1},
		'{8'h50, 1'b1, 32'h12340010, 40'h0, 1'b1, 1'b1},
		'{8'hf0, 1'b1, 32'h00000001, 40'h0, 1'b1, 1'b0}
	};

	always #2.5 clk = ~clk;

	atm_cell_header_screen_ctrl DUT (
		.CLK_I                  (clk),
		.RESET_N_I              (rst_n),
		.ADDR_I                 (addr),
		.WR_DATA_I              (wdata),
		.WR_STROBE_I            (wr),
		.RD_STROBE_I            (rd),
		.RD_DATA_O              (rd_data),
		.TX_IDLE_OCTET1_I       (8'hc3),
		.TX_IDLE_HEADER_O       (idle_hdr),
		.RX_MATCH_OCTET34_I     (16'h0000),
		.RX_HEADER_MASK_I       (32'h0000ffff),
		.RX_IDLE_HEADER_VALUE_I (32'h00000001),
		.RX_IDLE_HEADER_MASK_I  (32'h00000000),
		.CELL_ALIGNED_I         (aligned),
		.RX_DATA_I              (rx_data),
		.RX_VALID_I             (rx_valid),
		.RX_SOC_I               (rx_soc),
		.CELL_DATA_O            (cell_data),
		.CELL_VALID_O           (cell_valid),
		.CELL_SOC_O             (cell_soc),
		.HEC_DETECT_MODE_O      ()
	);

	cell_source src (
		.clk_i   (clk),
		.data_o  (rx_data),
		.valid_o (rx_valid),
		.soc_o   (rx_soc)
	);

	// ----------------------------------------------------------------
	// Output monitor
	// ----------------------------------------------------------------
	always @(posedge clk)
		if (cell_valid === 1'b1)
		begin
			if (n_out == 0)
			begin
				first_data = cell_data;
				first_soc  = cell_soc;
			end
			last_data = cell_data;
			n_out++;
		end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr  = a;
		wdata = d;
		wr    = 1'b1;
		@(posedge clk);
		#1;
		wr    = 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd   = 1'b1;
		@(posedge clk);
		#1;
		rd   = 1'b0;
		d    = rd_data;
	endtask

	// Test cell then a dropped idle filler that pushes the tail out
	task automatic run_cell(input cell_row_t r);
		reg_wr(8'h08, r.ctrl);
		aligned = r.aligned;
		n_out   = 0;
		src.send(r.hdr, r.flip, r.coset);
		reg_wr(8'h08, 8'h70);
		aligned = 1'b1;
		src.send(32'h00000001, 40'h0, 1'b1);
	endtask

	task automatic do_reset();
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		do_reset();
		repeat (2) @(posedge clk);
		check(idle_hdr, 32'hc3000001);
		// Reset value, write, read back; 0x09 is unmapped
		for (int i = 0; i < 7; i++)
		begin
			logic [7:0] a;
			logic [7:0] rv;
			a  = (i == 0) ? 8'h08 : (i == 6) ? 8'h09 : 8'h20 + i[7:0];
			rv = (i == 0) ? 8'h70 : (i == 3) ? 8'h01 : 8'h00;
			reg_rd(a, got);
			check(got, rv);
			reg_wr(a, 8'ha5 ^ i[7:0]);
			reg_rd(a, got);
			check(got, (i == 6) ? 8'h00 : 8'ha5 ^ i[7:0]);
		end
		@(posedge clk);
		check(idle_hdr, {8'hc3, 8'ha4, 8'ha7, 8'ha6});
		// Write and read in one cycle see the old value
		@(posedge clk);
		#1;
		addr  = 8'h23;
		wdata = 8'h5e;
		wr    = 1'b1;
		rd    = 1'b1;
		@(posedge clk);
		#1;
		wr    = 1'b0;
		rd    = 1'b0;
		check(rd_data, 8'ha6);
		@(posedge clk);
		#1;
		check(idle_hdr[7:0], 8'h5e);
		reg_wr(8'h24, 8'h12);
		reg_wr(8'h25, 8'h34);
		for (int i = 0; i < 14; i++)
		begin
			run_cell(rows[i]);
			check(n_out, rows[i].keep ? 53 : 0);
			if (rows[i].keep)
			begin
				check({first_soc, first_data}, {1'b1, rows[i].hdr[31:24]});
				if (rows[i].ctrl[5] == 1'b0)
					check(last_data, 8'h34);
			end
		end
		// Disable written mid-cell leaves the running cell whole
		n_out = 0;
		fork
			src.send(32'h12340010, 40'h0, 1'b1);
			begin
				repeat (20) @(posedge clk);
				reg_wr(8'h08, 8'h72);
			end
		join
		reg_wr(8'h08, 8'h70);
		src.send(32'h00000001, 40'h0, 1'b1);
		check(n_out, 53);
		// Idle cell kept once deletion is off
		run_cell('{8'hb0, 1'b1, 32'h00000001, 40'h0, 1'b1, 1'b1});
		check(n_out, 53);
		// Second reset in mid-run
		do_reset();
		reg_rd(8'h08, got);
		check(got, 8'h70);
		reg_rd(8'h24, got);
		check(got, 8'h00);
		check(idle_hdr, 32'hc3000001);
		end_sim();
	end
endmodule
